// ---- qpe_map.svh ----
/*
 * register offsets, field positions and reset values of the quadrature
 * position and input event block.
 * assumes byte addressing on a 32-bit register bus, one aligned word per register.
 */
`ifndef QPE_MAP_SVH
`define QPE_MAP_SVH

// register byte offsets
`define QPE_CTRL_OFS 8'h00
`define QPE_STAT_OFS 8'h04
`define QPE_MASK_OFS 8'h08
`define QPE_EDGE_OFS 8'h0c
`define QPE_POSLO_OFS 8'h10
`define QPE_POSHI_OFS 8'h14
`define QPE_TGTLO_OFS 8'h18
`define QPE_TGTHI_OFS 8'h1c
`define QPE_PINS_OFS 8'h20
`define QPE_HALL_OFS 8'h24

// control fields
`define QPE_CTRL_SWAP 0
`define QPE_CTRL_H120 1
`define QPE_CTRL_REARM 2

// status and mask fields: inputs 0..3 in bits 3:0
`define QPE_ST_POS 4
`define QPE_ST_ERR 5
`define QPE_ST_W 6

// hall register fields
`define QPE_HALL_INIT_VALID 7

// reset values
`define QPE_CTRL_RST 2'h0
`define QPE_MASK_RST 6'h00
`define QPE_EDGE_RST 8'h00
`define QPE_POS_RST 64'h0
`define QPE_TGT_RST 64'h0

// bus responses
`define QPE_RESP_OKAY 2'h0
`define QPE_RESP_SLVERR 2'h2

`endif

// ---- qpe_pkg.sv ----
/*
 * types shared by the quadrature position and input event block.
 * assumes the map header is compiled alongside.
 */
package qpe_pkg;
    // per-input interrupt edge choice, two bits per input
    typedef enum logic [1:0] {QPE_EDGE_OFF, QPE_EDGE_RISE, QPE_EDGE_FALL, QPE_EDGE_BOTH} qpe_edge_e;
    // signed position count
    typedef logic signed [63:0] qpe_pos_t;
endpackage

// ---- qpe_lvl_if.sv ----
/*
 * carrier for synchronised pin levels and their one-cycle edge pulses.
 * assumes one producer (the synchroniser) and any number of readers.
 */
`timescale 1ns/10ps
interface qpe_lvl_if #(parameter int W = 9);
    logic [W-1:0] lvl;  // settled level
    logic [W-1:0] rise; // one-cycle pulse on a settled rise
    logic [W-1:0] fall; // one-cycle pulse on a settled fall
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface

// ---- qpe_sync.sv ----
/*
 * three-stage pin synchroniser with settled level and edge pulses.
 * assumes the pins are asynchronous to clk; a change counts once stages two and three agree.
 */
`timescale 1ns/10ps
module qpe_sync #(
    parameter int W = 9,
    parameter logic [8:0] RST_VAL = 9'h000
) (
    input wire logic clk, // system clock
    input wire logic srst, // synchronous reset, high
    input wire logic [W-1:0] pin, // raw pins
    qpe_lvl_if.src out // settled levels and edges
);
    logic [W-1:0] s1; // first stage, read only by s2
    logic [W-1:0] s2; // second stage
    logic [W-1:0] s3; // third stage
    logic [W-1:0] next_lvl; // settled level after this edge
    logic [W-1:0] next_rise; // rise pulse after this edge
    logic [W-1:0] next_fall; // fall pulse after this edge

    // a bit settles only where the last two stages agree, so a metastable blip is ignored
    always_comb
    begin
        next_lvl = (s2 & s3) | (out.lvl & (s2 ^ s3));
        next_rise = next_lvl & ~out.lvl;
        next_fall = ~next_lvl & out.lvl;
    end

    // sampling chain and registered outputs
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            s1 <= RST_VAL[W-1:0];
            s2 <= RST_VAL[W-1:0];
            s3 <= RST_VAL[W-1:0];
            out.lvl <= RST_VAL[W-1:0];
            out.rise <= '0;
            out.fall <= '0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            out.lvl <= next_lvl;
            out.rise <= next_rise;
            out.fall <= next_fall;
        end
    end
endmodule // qpe_sync

// ---- qpe_quad.sv ----
/*
 * quadrature step decoder: one step per settled edge of either phase.
 * assumes phase a in lvl bit 0 and phase b in bit 1, both from the synchroniser.
 */
`timescale 1ns/10ps
module qpe_quad (
    input wire logic clk, // system clock
    input wire logic srst, // synchronous reset, high
    input wire logic swap, // exchange phases a and b
    qpe_lvl_if.dst ins, // settled encoder levels
    output logic step, // one-cycle count pulse
    output logic cw, // direction of step, high for clockwise
    output logic err // one-cycle pulse: both phases moved at once
);
    logic a; // phase a after swap
    logic b; // phase b after swap
    logic ca; // phase a changed
    logic cb; // phase b changed
    logic next_step; // step after this edge
    logic next_cw; // direction after this edge
    logic next_err; // error after this edge

    // a leading b (00,10,11,01) is clockwise, so a rise of a with b high is counter-clockwise
    always_comb
    begin
        a = swap ? ins.lvl[1] : ins.lvl[0];
        b = swap ? ins.lvl[0] : ins.lvl[1];
        ca = swap ? (ins.rise[1] | ins.fall[1]) : (ins.rise[0] | ins.fall[0]);
        cb = swap ? (ins.rise[0] | ins.fall[0]) : (ins.rise[1] | ins.fall[1]);
        next_step = ca ^ cb;
        next_cw = ca ? (a ^ b) : ~(a ^ b);
        next_err = ca & cb;
    end

    // registered pulses
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            step <= 1'b0;
            cw <= 1'b0;
            err <= 1'b0;
        end
        else
        begin
            step <= next_step;
            cw <= next_cw;
            err <= next_err;
        end
    end
endmodule // qpe_quad

// ---- qpe_top.sv ----
/*
 * quadrature position counter, hall phase finder and input interrupt logic
 * behind an axi4-lite register slave.
 * assumes asynchronous encoder, hall and input pins; one clock CLK.
 */
// Function
// - 64-bit count, one per edge of either phase
// - a leading b counts clockwise
// - a rising with b high counts counter-clockwise
// - software swap exchanges the two phases
// - each input interrupts on rise, fall or both
// - interrupt when position reaches programmed target
// - open input reads high, grounded reads low
// - hall inputs give initial phase, 60 or 120
`timescale 1ns/10ps
`include "qpe_map.svh"
module qpe_top #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK, // system clock, 50 MHz
    input wire logic SRST, // synchronous reset, high
    input wire logic ENC_A, // encoder phase a pin
    input wire logic ENC_B, // encoder phase b pin
    input wire logic [2:0] HALL, // hall sensors a,b,c
    input wire logic [3:0] DIN, // isolated digital inputs
    output logic IRQ, // level interrupt
    input wire logic [ADDR_W-1:0] S_AXI_AWADDR, // write address
    input wire logic S_AXI_AWVALID, // write address valid
    output logic S_AXI_AWREADY, // write address ready
    input wire logic [31:0] S_AXI_WDATA, // write data
    input wire logic [3:0] S_AXI_WSTRB, // byte enables
    input wire logic S_AXI_WVALID, // write data valid
    output logic S_AXI_WREADY, // write data ready
    output logic [1:0] S_AXI_BRESP, // write response
    output logic S_AXI_BVALID, // write response valid
    input wire logic S_AXI_BREADY, // write response ready
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // read address
    input wire logic S_AXI_ARVALID, // read address valid
    output logic S_AXI_ARREADY, // read address ready
    output logic [31:0] S_AXI_RDATA, // read data
    output logic [1:0] S_AXI_RRESP, // read response
    output logic S_AXI_RVALID, // read data valid
    input wire logic S_AXI_RREADY // read data ready
);
    import qpe_pkg::*;

    // merge a write into a register under its byte enables
    function automatic logic [31:0] qpe_wmerge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
            begin
                r[8*i +: 8] = d[8*i +: 8];
            end
        end
        return r;
    endfunction

    // does an edge pulse pair hit the chosen edge kind
    function automatic logic qpe_edge_hit(input logic [1:0] sel, input logic r, input logic f);
        qpe_edge_e e;
        e = qpe_edge_e'(sel);
        case (e)
            QPE_EDGE_RISE: return r;
            QPE_EDGE_FALL: return f;
            QPE_EDGE_BOTH: return r | f;
            default: return 1'b0;
        endcase
    endfunction

    // hall code to sector: {valid, sector}; 60 degree codes map to 120 by flipping sensor b
    function automatic logic [3:0] qpe_hall_sector(input logic [2:0] h, input logic h120);
        logic [2:0] c;
        c = h120 ? h : (h ^ 3'h2);
        case (c)
            3'h5: return 4'h8;
            3'h4: return 4'h9;
            3'h6: return 4'ha;
            3'h2: return 4'hb;
            3'h3: return 4'hc;
            3'h1: return 4'hd;
            default: return 4'h0;
        endcase
    endfunction

    // synchronised pins: bit0 a, bit1 b, bits 4:2 hall, bits 8:5 inputs
    qpe_lvl_if #(.W(9)) pins ();

    // inputs settle high, as an open switch would read
    // hall settles at 101, invalid at the reset spacing, so no stale initial phase is caught
    qpe_sync #(.W(9), .RST_VAL(9'h1f4)) u_sync (
        .clk(CLK),
        .srst(SRST),
        .pin({DIN, HALL, ENC_B, ENC_A}),
        .out(pins)
    );

    logic [1:0] ctrl; // swap and hall spacing
    logic q_step; // decoder count pulse
    logic q_cw; // decoder direction
    logic q_err; // decoder double-change pulse

    qpe_quad u_quad (
        .clk(CLK),
        .srst(SRST),
        .swap(ctrl[`QPE_CTRL_SWAP]),
        .ins(pins),
        .step(q_step),
        .cw(q_cw),
        .err(q_err)
    );

    // register state
    qpe_pos_t pos; // position count
    qpe_pos_t tgt; // target position
    logic [`QPE_ST_W-1:0] stat; // sticky event bits
    logic [`QPE_ST_W-1:0] mask; // interrupt enables
    logic [7:0] edge_sel; // two bits per input
    logic [31:0] pos_hi_snap; // upper count word caught on low-word read
    logic init_valid; // initial hall sector caught
    logic [2:0] init_sector; // initial hall sector
    logic [1:0] next_ctrl;
    qpe_pos_t next_pos;
    qpe_pos_t next_tgt;
    logic [`QPE_ST_W-1:0] next_stat;
    logic [`QPE_ST_W-1:0] next_mask;
    logic [7:0] next_edge_sel;
    logic [31:0] next_pos_hi_snap;
    logic next_init_valid;
    logic [2:0] next_init_sector;

    // bus state
    logic aw_got; // write address held
    logic w_got; // write data held
    logic [ADDR_W-1:0] aw_addr; // held write address
    logic [31:0] w_data; // held write data
    logic [3:0] w_strb; // held byte enables
    logic [ADDR_W-1:0] next_aw_addr;
    logic [31:0] next_w_data;
    logic [3:0] next_w_strb;
    logic next_aw_got;
    logic next_w_got;
    logic next_bvalid;
    logic [1:0] next_bresp;
    logic next_rvalid;
    logic [1:0] next_rresp;
    logic [31:0] next_rdata;

    // decode helpers
    logic wr_do; // both halves present, perform write
    logic rd_do; // read address taken
    logic [3:0] hall_now; // live hall sector with valid
    logic [`QPE_ST_W-1:0] events; // this cycle's events
    logic [31:0] wm; // merged write value scratch

    // handshake readies are combinational: free while nothing is held or answered
    assign S_AXI_AWREADY = ~aw_got & ~S_AXI_BVALID;
    assign S_AXI_WREADY = ~w_got & ~S_AXI_BVALID;
    assign S_AXI_ARREADY = ~S_AXI_RVALID;
    assign wr_do = aw_got & w_got;
    assign rd_do = S_AXI_ARVALID & S_AXI_ARREADY;
    assign IRQ = |(stat & mask);

    // live hall sector, spacing picked by software
    assign hall_now = qpe_hall_sector(pins.lvl[4:2], ctrl[`QPE_CTRL_H120]);

    // events gathered into one vector
    always_comb
    begin
        events = '0;
        for (int i = 0; i < 4; i++)
        begin
            events[i] = qpe_edge_hit(edge_sel[2*i +: 2], pins.rise[5+i], pins.fall[5+i]);
        end
        events[`QPE_ST_POS] = q_step & (next_pos == tgt);
        events[`QPE_ST_ERR] = q_err;
    end

    // register file and position next values
    always_comb
    begin
        next_ctrl = ctrl;
        next_tgt = tgt;
        next_mask = mask;
        next_edge_sel = edge_sel;
        next_pos_hi_snap = pos_hi_snap;
        next_init_valid = init_valid;
        next_init_sector = init_sector;
        next_stat = stat;
        wm = '0;
        // up or down by one per step
        next_pos = pos;
        if (q_step)
        begin
            next_pos = q_cw ? pos + 64'sd1 : pos - 64'sd1;
        end
        // first valid hall code gives the initial phase
        if (!init_valid && hall_now[3])
        begin
            next_init_valid = 1'b1;
            next_init_sector = hall_now[2:0];
        end
        // low-word read freezes the upper word so a 64-bit read is coherent
        if (rd_do && S_AXI_ARADDR == `QPE_POSLO_OFS)
        begin
            next_pos_hi_snap = pos[63:32];
        end
        if (wr_do)
        begin
            case (aw_addr)
                `QPE_CTRL_OFS:
                begin
                    wm = qpe_wmerge({30'h0, ctrl}, w_data, w_strb);
                    next_ctrl = wm[1:0];
                    // re-arm the hall capture for a fresh initial phase
                    if (wm[`QPE_CTRL_REARM])
                    begin
                        next_init_valid = 1'b0;
                    end
                end
                `QPE_STAT_OFS:
                begin
                    wm = qpe_wmerge(32'h0, w_data, w_strb);
                    next_stat = stat & ~wm[`QPE_ST_W-1:0];
                end
                `QPE_MASK_OFS:
                begin
                    wm = qpe_wmerge({26'h0, mask}, w_data, w_strb);
                    next_mask = wm[`QPE_ST_W-1:0];
                end
                `QPE_EDGE_OFS:
                begin
                    wm = qpe_wmerge({24'h0, edge_sel}, w_data, w_strb);
                    next_edge_sel = wm[7:0];
                end
                `QPE_TGTLO_OFS: next_tgt[31:0] = qpe_wmerge(tgt[31:0], w_data, w_strb);
                `QPE_TGTHI_OFS: next_tgt[63:32] = qpe_wmerge(tgt[63:32], w_data, w_strb);
                // other offsets are read-only or unmapped
                default: wm = '0;
            endcase
        end
        // a new event wins over a clear in the same cycle
        next_stat = next_stat | events;
    end

    // register file flops
    always_ff @(posedge CLK)
    begin
        // reset clears count, interrupts and swap
        if (SRST)
        begin
            ctrl <= `QPE_CTRL_RST;
            pos <= `QPE_POS_RST;
            tgt <= `QPE_TGT_RST;
            stat <= '0;
            mask <= `QPE_MASK_RST;
            edge_sel <= `QPE_EDGE_RST;
            pos_hi_snap <= '0;
            init_valid <= 1'b0;
            init_sector <= '0;
        end
        else
        begin
            ctrl <= next_ctrl;
            pos <= next_pos;
            tgt <= next_tgt;
            stat <= next_stat;
            mask <= next_mask;
            edge_sel <= next_edge_sel;
            pos_hi_snap <= next_pos_hi_snap;
            init_valid <= next_init_valid;
            init_sector <= next_init_sector;
        end
    end

    // bus channel next values
    always_comb
    begin
        next_aw_got = aw_got;
        next_w_got = w_got;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = S_AXI_BVALID;
        next_bresp = S_AXI_BRESP;
        next_rvalid = S_AXI_RVALID;
        next_rresp = S_AXI_RRESP;
        next_rdata = S_AXI_RDATA;
        if (S_AXI_AWVALID && S_AXI_AWREADY)
        begin
            next_aw_got = 1'b1;
            next_aw_addr = S_AXI_AWADDR;
        end
        if (S_AXI_WVALID && S_AXI_WREADY)
        begin
            next_w_got = 1'b1;
            next_w_data = S_AXI_WDATA;
            next_w_strb = S_AXI_WSTRB;
        end
        // write performed: answer, and slverr for an address outside the map
        if (wr_do)
        begin
            next_aw_got = 1'b0;
            next_w_got = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (aw_addr <= `QPE_HALL_OFS && aw_addr[1:0] == 2'h0) ? `QPE_RESP_OKAY : `QPE_RESP_SLVERR;
        end
        else if (S_AXI_BVALID && S_AXI_BREADY)
        begin
            next_bvalid = 1'b0;
        end
        if (rd_do)
        begin
            next_rvalid = 1'b1;
            next_rresp = `QPE_RESP_OKAY;
            case (S_AXI_ARADDR)
                `QPE_CTRL_OFS: next_rdata = {30'h0, ctrl};
                `QPE_STAT_OFS: next_rdata = {26'h0, stat};
                `QPE_MASK_OFS: next_rdata = {26'h0, mask};
                `QPE_EDGE_OFS: next_rdata = {24'h0, edge_sel};
                `QPE_POSLO_OFS: next_rdata = pos[31:0];
                `QPE_POSHI_OFS: next_rdata = pos_hi_snap;
                `QPE_TGTLO_OFS: next_rdata = tgt[31:0];
                `QPE_TGTHI_OFS: next_rdata = tgt[63:32];
                `QPE_PINS_OFS: next_rdata = {23'h0, pins.lvl};
                `QPE_HALL_OFS: next_rdata = {24'h0, init_valid, init_sector, hall_now};
                default:
                begin
                    next_rdata = '0;
                    next_rresp = `QPE_RESP_SLVERR;
                end
            endcase
        end
        else if (S_AXI_RVALID && S_AXI_RREADY)
        begin
            next_rvalid = 1'b0;
        end
    end

    // bus channel flops
    always_ff @(posedge CLK)
    begin
        if (SRST)
        begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= `QPE_RESP_OKAY;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RRESP <= `QPE_RESP_OKAY;
            S_AXI_RDATA <= '0;
        end
        else
        begin
            aw_got <= next_aw_got;
            w_got <= next_w_got;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            S_AXI_BVALID <= next_bvalid;
            S_AXI_BRESP <= next_bresp;
            S_AXI_RVALID <= next_rvalid;
            S_AXI_RRESP <= next_rresp;
            S_AXI_RDATA <= next_rdata;
        end
    end
endmodule // qpe_top

// ---- qpe_top_asserts.sv ----
/*
 checker for the register bus, reset and interrupt behaviour of qpe_top.
 assumes it is bound into qpe_top and sees only its ports.
*/
`timescale 1ns/10ps
module qpe_top_asserts #(
    parameter int ADDR_W = 8
) (
    input wire logic CLK, // clock
    input wire logic SRST, // reset, high
    input wire logic IRQ, // interrupt
    input wire logic S_AXI_AWVALID, // aw valid
    input wire logic S_AXI_AWREADY, // aw ready
    input wire logic S_AXI_WVALID, // w valid
    input wire logic S_AXI_WREADY, // w ready
    input wire logic [1:0] S_AXI_BRESP, // b resp
    input wire logic S_AXI_BVALID, // b valid
    input wire logic S_AXI_BREADY, // b ready
    input wire logic [ADDR_W-1:0] S_AXI_ARADDR, // ar addr
    input wire logic S_AXI_ARVALID, // ar valid
    input wire logic S_AXI_ARREADY, // ar ready
    input wire logic [31:0] S_AXI_RDATA, // r data
    input wire logic [1:0] S_AXI_RRESP, // r resp
    input wire logic S_AXI_RVALID, // r valid
    input wire logic S_AXI_RREADY // r ready
);
    // one domain, so clock and disable are shared
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    // reset must be seen while it is held, hence no disable here
    a_reset_quiet: assert property (disable iff (1'b0) SRST |=> !IRQ && !S_AXI_BVALID && !S_AXI_RVALID)
        else $error("outputs busy after reset");
    a_b_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
        else $error("write answer dropped");
    a_r_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
        else $error("read answer dropped");
    a_r_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
        else $error("read answer late");
    a_w_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
        |=> !S_AXI_BVALID ##1 S_AXI_BVALID)
        else $error("write answer off time");
    a_busy_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
        else $error("write taken while answering");
    a_rd_refuse: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read taken while answering");
    a_bad_addr: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR > 8'h24
        |=> S_AXI_RRESP == 2'h2 && S_AXI_RDATA == 32'h0)
        else $error("unmapped read answered");
    // sticky events only drop through a register write
    a_irq_sticky: assert property ($fell(IRQ) |-> $rose(S_AXI_BVALID))
        else $error("interrupt fell without write");
endmodule // qpe_top_asserts

// ---- qpe_motor_model.sv ----
/*
 model of the encoder, hall sensors and input switches at the far side.
 assumes the caller runs its tasks one at a time, right after a clock edge.
*/
`timescale 1ns/10ps
module qpe_motor_model (
    input wire logic CLK, // system clock
    output logic ENC_A, // phase a
    output logic ENC_B, // phase b
    output logic [2:0] HALL, // hall sensors
    output logic [3:0] DIN // input switches
);
    logic [1:0] ph; // position in the gray cycle
    initial
    begin
        ph = 2'h0;
        ENC_A = 1'b0;
        ENC_B = 1'b0;
        HALL = 3'h5;
        DIN = 4'hf;
    end
    function automatic logic [1:0] ab(input logic [1:0] i);
        ab = (i == 2'h0) ? 2'b00 : (i == 2'h1) ? 2'b10 : (i == 2'h2) ? 2'b11 : 2'b01;
    endfunction
    // one edge, then a rest of gap cycles (fast or slow motor)
    task step(input logic cw, input int gap);
        @(posedge CLK);
        ph = cw ? ph + 2'h1 : ph - 2'h1;
        {ENC_A, ENC_B} <= ab(ph);
        repeat (gap) @(posedge CLK);
    endtask
    // fault: both phases flip in one sample
    task both();
        @(posedge CLK);
        ph = ph + 2'h2;
        {ENC_A, ENC_B} <= ab(ph);
        repeat (8) @(posedge CLK);
    endtask
    task pins(input logic [2:0] h, input logic [3:0] d);
        @(posedge CLK);
        HALL <= h;
        DIN <= d;
        repeat (8) @(posedge CLK);
    endtask
endmodule // qpe_motor_model

// ---- qpe_top_tb_top.sv ----
/*
 self-checking bench for qpe_top with an axi4-lite master and a motor model.
 assumes the design files and the checker are compiled first.
*/
`timescale 1ns/10ps
module qpe_top_tb_top;
    import qpe_pkg::*;
    logic CLK = 1'b0, SRST = 1'b1, IRQ, ENC_A, ENC_B; // clock, reset, pins
    logic [2:0] HALL; // hall pins
    logic [3:0] DIN, S_AXI_WSTRB = 4'hf; // inputs, strobes
    logic [7:0] S_AXI_AWADDR = 8'h0, S_AXI_ARADDR = 8'h0; // addresses
    logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, rv, hv; // data
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, rs; // responses
    logic S_AXI_AWVALID = 0, S_AXI_AWREADY, S_AXI_WVALID = 0, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY = 0;
    logic S_AXI_ARVALID = 0, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY = 0, c; // read side
    int err_total = 0, tests_run = 0, seed = 98, m, i; // counters
    qpe_pos_t ep, t; // expected position, target
    always #10 CLK = ~CLK;
    qpe_top dut (.CLK, .SRST, .ENC_A, .ENC_B, .HALL, .DIN, .IRQ, .S_AXI_AWADDR, .S_AXI_AWVALID,
        .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP,
        .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA,
        .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
    qpe_motor_model mdl (.CLK, .ENC_A, .ENC_B, .HALL, .DIN);
    task tally_and_finish();
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // write: both halves offered together, each released when taken
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= d;
        S_AXI_AWVALID <= 1'b1;
        S_AXI_WVALID <= 1'b1;
        S_AXI_BREADY <= 1'b1;
        do
        begin
            @(posedge CLK);
            if (S_AXI_AWREADY)
                S_AXI_AWVALID <= 1'b0;
            if (S_AXI_WREADY)
                S_AXI_WVALID <= 1'b0;
        end
        while ((S_AXI_AWVALID && !S_AXI_AWREADY) || (S_AXI_WVALID && !S_AXI_WREADY));
        do @(posedge CLK); while (!S_AXI_BVALID);
        rs = S_AXI_BRESP;
        S_AXI_BREADY <= 1'b0;
    endtask
    task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge CLK);
        S_AXI_ARADDR <= a;
        S_AXI_ARVALID <= 1'b1;
        S_AXI_RREADY <= 1'b1;
        do @(posedge CLK); while (!S_AXI_ARREADY);
        S_AXI_ARVALID <= 1'b0;
        do @(posedge CLK); while (!S_AXI_RVALID);
        d = S_AXI_RDATA;
        r = S_AXI_RRESP;
        S_AXI_RREADY <= 1'b0;
    endtask
    // low word first, it freezes the high word
    task chkpos(input qpe_pos_t e);
        rd(8'h10, rv, rs);
        rd(8'h14, hv, rs);
        chk({hv, rv}, e);
    endtask
    task walk(input logic cw, input int n);
        repeat (n) mdl.step(cw, 8);
        ep = cw ? ep + n : ep - n;
    endtask
    // hang guard at 30000 cycles, far beyond the one to two thousand cycles needed
    initial
    begin
        #600000;
        err_total++;
        tally_and_finish();
    end
    initial
    begin
        ep = 0;
        repeat (4) @(posedge CLK);
        SRST <= 1'b0;
        for (m = 0; m < 8; m++)
        begin
            rd(8'(m * 4), rv, rs);
            chk(rv, 0);
        end
        rd(8'h28, rv, rs);
        chk(rs, 2'h2);
        wr(8'h2c, 32'h1);
        chk(rs, 2'h2);
        // random walk with random gaps, then forced below zero
        repeat (40)
        begin
            c = 1'($random(seed));
            mdl.step(c, 6 + ($random(seed) & 7));
            ep = c ? ep + 1 : ep - 1;
        end
        walk(1'b0, 50);
        chkpos(ep);
        // swap only where a and b are equal, so no edge appears
        if (mdl.ph[0])
            walk(1'b1, 1);
        wr(8'h00, 32'h1);
        walk(1'b1, 6);
        ep = ep - 12;
        chkpos(ep);
        wr(8'h00, 32'h0);
        mdl.both();
        chkpos(ep);
        rd(8'h04, rv, rs);
        chk(rv[5], 1'b1);
        wr(8'h04, 32'h30);
        t = ep + 3;
        wr(8'h18, t[31:0]);
        wr(8'h1c, t[63:32]);
        wr(8'h08, 32'h10);
        chk(rs, 2'h0);
        walk(1'b1, 2);
        chk(IRQ, 1'b0);
        walk(1'b1, 1);
        chk(IRQ, 1'b1);
        wr(8'h04, 32'h10);
        chk(IRQ, 1'b0);
        // rise, fall and both edge modes on a random input, fall then rise
        for (m = 1; m < 4; m++)
        begin
            i = $random(seed) & 3;
            wr(8'h0c, 32'(m) << (2 * i));
            wr(8'h08, 32'h1 << i);
            mdl.pins(3'h5, ~(4'h1 << i));
            rd(8'h04, rv, rs);
            chk(rv[3:0], m[1] ? 4'h1 << i : 4'h0);
            rd(8'h20, rv, rs);
            chk(rv[8:5], 4'(~(4'h1 << i)));
            wr(8'h04, 32'hf);
            mdl.pins(3'h5, 4'hf);
            chk(IRQ, m[0]);
            wr(8'h04, 32'hf);
        end
        wr(8'h00, 32'h2);
        mdl.pins(3'b110, 4'hf);
        rd(8'h24, rv, rs);
        chk(rv[3:0], 4'ha);
        wr(8'h00, 32'h6);
        rd(8'h24, rv, rs);
        chk(rv[7:0], 8'haa);
        mdl.pins(3'b111, 4'hf);
        rd(8'h24, rv, rs);
        chk(rv[3], 1'b0);
        wr(8'h00, 32'h0);
        mdl.pins(3'b100, 4'hf);
        rd(8'h24, rv, rs);
        chk(rv[3:0], 4'ha);
        // park at gray zero so the reset level matches the encoder pins
        while (mdl.ph != 2'h0)
            walk(1'b1, 1);
        @(posedge CLK);
        SRST <= 1'b1;
        repeat (4) @(posedge CLK);
        SRST <= 1'b0;
        chkpos(0);
        rd(8'h08, rv, rs);
        chk(rv, 0);
        tally_and_finish();
    end
endmodule // qpe_top_tb_top
bind qpe_top qpe_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.CLK, .SRST, .IRQ, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR,
    .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
